// >>> src/tcs_pkg.sv
package tcs_pkg;
	localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h4c;
	localparam logic [6:0] SLAVE_ADDR_MIN     = 7'h08;
	localparam logic [6:0] SLAVE_ADDR_MAX     = 7'h77;
	localparam logic [7:0] TAP_STATUS_OFFSET  = 8'h03;
	localparam logic [7:0] INT_SETUP_OFFSET   = 8'h06;
	localparam logic [7:0] TAP_AXIS_OFFSET    = 8'h09;
	localparam logic [7:0] TAP_DEBOUNCE_OFFSET = 8'h0a;
	localparam logic [7:0] REG_RESET          = 8'h00;
	localparam logic [7:0] PTR_RESET          = 8'h00;
	localparam int         Z_DIS_BIT          = 7;
	localparam int         Y_DIS_BIT          = 6;
	localparam int         X_DIS_BIT          = 5;
	localparam int         TAP_FLAG_BIT       = 5;
	localparam int         TAP_INT_EN_BIT     = 2;
	localparam logic [3:0] BIT_LAST           = 4'h7;
	localparam logic [3:0] BIT_ACK            = 4'h8;
	// nominal time per debounce test, in ns; 0.52 ms covers two tests
	localparam int         TEST_TIME_NS       = 260000;
	localparam int         CLK_PERIOD_NS      = 50;
	localparam int         TEST_CYCLES        = TEST_TIME_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ADDR  = 3'b001,
		ST_PTR   = 3'b010,
		ST_WDATA = 3'b011,
		ST_RDATA = 3'b100,
		ST_IGN   = 3'b101
	} tcs_state_type;

	typedef struct packed {
		logic       zDis;
		logic       yDis;
		logic       xDis;
		logic [4:0] threshold;
	} tcs_axis_type;

	typedef struct packed {
		logic [5:0] magnitude;
		logic [2:0] axisHit;
	} tcs_sample_type;
endpackage

// >>> src/tcs_tap_config_i2c_slave.sv
`timescale 1ns/100ps
// How it works
// RULE_01: bits 7..5 of axis register disable z, y, x tap detection when set.
// RULE_02: bits 4:0 give the tap threshold in counts.
// RULE_03: all axes enabled, 120 sps, auto-sleep on: tap restarts sleep counter. Code also requires tapIntEnable set.
// RULE_04: debounce value n needs n+1 equal consecutive test results.
// RULE_05: tap sets status flag; interrupt only when tap interrupt enable set.
// RULE_06: one test per fixed period, so response grows linearly with count.
// RULE_07: master starts transfers and clocks; device is only a slave.
// RULE_08: clock line input only; data line input and pull-low output.
// RULE_09: transfer is start, address, pointer, data bytes, stop.
// RULE_10: both lines idle high; device never pulls data low when idle.
// RULE_11: start is data falling with clock high, stop data rising.
// RULE_12: one bit per clock pulse; data stable while clock high.
// RULE_13: ninth clock carries acknowledge, receiver pulls data low.
// RULE_14: master acknowledges each byte it reads.
// RULE_15: eighth bit low means write, high means read.
// RULE_16: slave address is a parameter, default 1001100.
// RULE_17: device watches for start plus own address and acknowledges.
// RULE_18: both tap registers readable, writable, reset to zero.
// RULE_19: stop forces the register pointer to zero.
// RULE_20: repeated start keeps the register pointer.
// RULE_21: pointer advances after every data byte written or read.
// RULE_22: first write byte is the pointer, later bytes are data.
// RULE_23: address mismatch leaves data released until the next start.
// RULE_24: not-acknowledge from master ends read driving.
module tcs_tap_config_i2c_slave
	import tcs_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEFAULT // [RULE_16]
) (
	input  wire logic           clk,
	input  wire logic           rst_n,
	input  wire logic           sclIn,
	input  wire logic           sdaIn,
	output logic                sdaOut,
	output logic                sdaOe,
	input  wire logic           sampleValid,
	input  wire tcs_sample_type sample,
	input  wire logic           rate120,
	input  wire logic           autoSleepEn,
	input  wire logic           tapIntEnable,
	input  wire logic           tapFlagClear,
	output logic                tapFlag,
	output logic                tapEvent,
	output logic                tapIrq,
	output logic                sleepCountReset,
	output logic [7:0]          tapAxisThreshold,
	output logic [7:0]          tapDebounceCount
);
	logic [1:0]    sclSync_q, sdaSync_q;
	logic          sclOld_q, sdaOld_q;
	tcs_state_type state_q, state_d;
	logic [3:0]    bitCnt_q;
	logic [7:0]    shift_q;
	logic [7:0]    ptr_q;
	logic          ackPhase_q;
	logic          ackReq_q;
	logic          nack_q;
	tcs_axis_type  axis_q;
	logic [7:0]    debounce_q;
	logic [15:0]   testTimer_q;
	logic [8:0]    agree_q;
	logic          tapFlag_q;
	logic          tapEvent_q, tapIrq_q, sleepRst_q;

	// only the second stage is read; first stage feeds it alone
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclSync_q <= 2'b11;
			sdaSync_q <= 2'b11;
			sclOld_q  <= 1'b1;
			sdaOld_q  <= 1'b1;
		end else begin
			sclSync_q <= {sclSync_q[0], sclIn}; // [RULE_08] [RULE_07]
			sdaSync_q <= {sdaSync_q[0], sdaIn};
			sclOld_q  <= sclSync_q[1];
			sdaOld_q  <= sdaSync_q[1];
		end
	end

	wire scl      = sclSync_q[1];
	wire sda      = sdaSync_q[1];
	wire sclRise  = scl & ~sclOld_q; // [RULE_12]
	wire sclFall  = ~scl & sclOld_q;
	wire startCnd = scl & sclOld_q & sdaOld_q & ~sda; // [RULE_11]
	wire stopCnd  = scl & sclOld_q & ~sdaOld_q & sda; // [RULE_11]
	wire byteDone = sclRise & (bitCnt_q == BIT_LAST) & ~ackPhase_q;
	wire [7:0] rxByte = {shift_q[6:0], sda};
	wire addrHit  = (rxByte[7:1] == SLAVE_ADDR); // [RULE_17]
	wire ackDone  = sclFall & ackPhase_q;
	wire ackStart = sclFall & (bitCnt_q == BIT_ACK) & ~ackPhase_q;

	function automatic logic [7:0] readReg(input logic [7:0] a, input tcs_axis_type ax,
		input logic [7:0] db);
		case (a)
			TAP_AXIS_OFFSET:     readReg = ax;
			TAP_DEBOUNCE_OFFSET: readReg = db;
			default:             readReg = 8'h00;
		endcase
	endfunction

	wire [7:0] rdByte = readReg(ptr_q, axis_q, debounce_q); // [RULE_18]
	wire [7:0] rdNext = readReg(ptr_q + 8'h01, axis_q, debounce_q); // [RULE_21]
	wire ackWanted = (state_q == ST_ADDR && addrHit) || state_q == ST_PTR
		|| state_q == ST_WDATA;

	always_comb begin
		state_d = state_q;
		if (startCnd) begin
			state_d = ST_ADDR; // [RULE_17]
		end else if (stopCnd) begin
			state_d = ST_IDLE;
		end else if (byteDone) begin
			case (state_q)
				ST_ADDR:  state_d = addrHit ? (rxByte[0] ? ST_RDATA : ST_PTR) : ST_IGN; // [RULE_15] [RULE_23]
				ST_PTR:   state_d = ST_WDATA; // [RULE_22]
				default:  state_d = state_q;
			endcase
		end else if (ackDone && state_q == ST_RDATA && nack_q && !ackReq_q) begin
			state_d = ST_IGN; // [RULE_24]
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// bit counter and shifter; ack phase is the ninth clock
	always_ff @(posedge clk) begin
		if (!rst_n || startCnd || stopCnd) begin
			bitCnt_q   <= 4'h0;
			ackPhase_q <= 1'b0;
			shift_q    <= 8'h00;
		end else if (byteDone) begin
			bitCnt_q   <= BIT_ACK;
			shift_q    <= rxByte;
		end else if (ackStart) begin
			ackPhase_q <= 1'b1; // [RULE_13]
		end else if (ackDone) begin
			bitCnt_q   <= 4'h0;
			ackPhase_q <= 1'b0;
		end else if (sclRise && bitCnt_q < BIT_ACK) begin
			bitCnt_q   <= bitCnt_q + 4'h1;
			shift_q    <= rxByte;
		end
	end

	// master acknowledge sampled on the ninth rising edge of a read
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			nack_q <= 1'b0;
		end else if (sclRise && ackPhase_q) begin
			nack_q <= sda; // [RULE_14]
		end
	end

	// pointer: kept on repeated start, cleared on stop
	always_ff @(posedge clk) begin
		if (!rst_n || stopCnd) begin // [RULE_20]
			ptr_q <= PTR_RESET; // [RULE_19]
		end else if (byteDone && state_q == ST_PTR) begin
			ptr_q <= rxByte; // [RULE_22]
		end else if (byteDone && state_q == ST_WDATA) begin
			ptr_q <= ptr_q + 8'h01; // [RULE_21]
		end else if (ackDone && state_q == ST_RDATA && !ackReq_q) begin
			ptr_q <= ptr_q + 8'h01; // [RULE_21]
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			axis_q     <= REG_RESET; // [RULE_18]
			debounce_q <= REG_RESET;
		end else if (byteDone && state_q == ST_WDATA) begin
			if (ptr_q == TAP_AXIS_OFFSET) begin
				axis_q <= rxByte;
			end
			if (ptr_q == TAP_DEBOUNCE_OFFSET) begin
				debounce_q <= rxByte;
			end
		end
	end

	// ack decided at bit 8, pulled from the next fall through the ninth pulse
	always_ff @(posedge clk) begin
		if (!rst_n || startCnd || stopCnd) begin
			ackReq_q <= 1'b0;
		end else if (byteDone) begin
			ackReq_q <= ackWanted; // [RULE_13]
		end
	end
	// read bits move on clock low only; ones shifted in release the line
	logic [7:0] txShift_q;
	always_ff @(posedge clk) begin
		if (!rst_n || startCnd || stopCnd) begin
			txShift_q <= 8'hff;
		end else if (ackDone && state_q == ST_RDATA && !nack_q) begin
			txShift_q <= ackReq_q ? rdByte : rdNext; // [RULE_21]
		end else if (sclFall && !ackPhase_q && state_q == ST_RDATA) begin
			txShift_q <= {txShift_q[6:0], 1'b1}; // [RULE_12]
		end
	end
	// output pin: pull low only, never drive high
	logic sdaOe_q;
	wire  rdDrive  = (state_q == ST_RDATA) && !ackPhase_q && !txShift_q[7];
	wire  ackDrive = ackPhase_q && ackReq_q; // [RULE_13]
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sdaOe_q <= 1'b0;
		end else begin
			sdaOe_q <= (state_q != ST_IDLE) && (ackDrive || rdDrive); // [RULE_08] [RULE_10]
		end
	end
	assign sdaOut = 1'b0;
	assign sdaOe  = sdaOe_q;

	// tap debounce: one test per period keeps response linear in the count
	wire testTick = (testTimer_q == 16'(TEST_CYCLES - 1)); // [RULE_06]
	wire hitNow   = sampleValid && sample.magnitude > {1'b0, axis_q.threshold} // [RULE_02]
		&& ((sample.axisHit[2] && !axis_q.zDis) || (sample.axisHit[1] && !axis_q.yDis)
		|| (sample.axisHit[0] && !axis_q.xDis)); // [RULE_01]
	wire declare  = testTick && hitNow && (agree_q == {1'b0, debounce_q}); // [RULE_04]
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			testTimer_q <= 16'h0000;
			agree_q     <= 9'h000;
		end else begin
			testTimer_q <= testTick ? 16'h0000 : testTimer_q + 16'h0001;
			// n earlier hits plus this one make n+1; saturate so a tap declares once
			if (testTick && hitNow && agree_q <= {1'b0, debounce_q}) begin
				agree_q <= agree_q + 9'h001; // [RULE_04]
			end else if (testTick && !hitNow) begin
				agree_q <= 9'h000;
			end
		end
	end

	// set beats clear when both land together
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tapFlag_q  <= 1'b0;
			tapEvent_q <= 1'b0;
			tapIrq_q   <= 1'b0;
			sleepRst_q <= 1'b0;
		end else begin
			tapFlag_q  <= declare | (tapFlag_q & ~tapFlagClear); // [RULE_05]
			tapEvent_q <= declare;
			tapIrq_q   <= declare & tapIntEnable; // [RULE_05]
			sleepRst_q <= declare & tapIntEnable & rate120 & autoSleepEn
				& ~axis_q.zDis & ~axis_q.yDis & ~axis_q.xDis; // [RULE_03]
		end
	end

	assign tapFlag          = tapFlag_q;
	assign tapEvent         = tapEvent_q;
	assign tapIrq           = tapIrq_q;
	assign sleepCountReset  = sleepRst_q;
	assign tapAxisThreshold = axis_q;
	assign tapDebounceCount = debounce_q;
endmodule // tcs_tap_config_i2c_slave

// >>> testbench/tcs_chk.sv
`timescale 1ns/100ps
module tcs_chk
	import tcs_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       sclIn,
	input wire logic       sdaIn,
	input wire logic       sdaOut,
	input wire logic       sdaOe,
	input wire logic       rate120,
	input wire logic       autoSleepEn,
	input wire logic       tapIntEnable,
	input wire logic       tapFlagClear,
	input wire logic       tapFlag,
	input wire logic       tapEvent,
	input wire logic       tapIrq,
	input wire logic       sleepCountReset,
	input wire logic [7:0] tapAxisThreshold,
	input wire logic [7:0] tapDebounceCount
);
	logic busIdle_q;
	logic sdaPrev_q;
	// bus idle is judged from the pins, not from the slave's own view
	always_ff @(posedge clk) begin
		sdaPrev_q <= sdaIn;
		if (!rst_n)
			busIdle_q <= 1'b1;
		else if (sclIn && sdaPrev_q && !sdaIn)
			busIdle_q <= 1'b0;
		else if (sclIn && !sdaPrev_q && sdaIn)
			busIdle_q <= 1'b1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence idleLong;
		busIdle_q [*5];
	endsequence
	chk_idle_free: assert property (idleLong |-> !sdaOe)
		else $error("data pulled low on idle bus");
	chk_scl_hold: assert property (sclIn && $past(sclIn) |-> $stable(sdaOe))
		else $error("data changed while clock high");
	chk_pull_low: assert property (sdaOut == 1'b0)
		else $error("data output not pull-low only");
	chk_irq_event: assert property (tapIrq |-> tapEvent)
		else $error("interrupt without tap event");
	chk_irq_gate: assert property (tapIrq |-> tapIntEnable || $past(tapIntEnable))
		else $error("interrupt while disabled");
	chk_flag_set: assert property (tapEvent |-> ##[0:1] tapFlag)
		else $error("tap flag not set");
	chk_flag_hold: assert property (tapFlag && !tapFlagClear |=> tapFlag)
		else $error("tap flag lost");
	chk_event_pulse: assert property (tapEvent |=> !tapEvent)
		else $error("tap event longer than a cycle");
	chk_sleep_cond: assert property (sleepCountReset |->
		tapAxisThreshold[7:5] == 3'b000 && rate120 && autoSleepEn)
		else $error("sleep restart without its condition");
	chk_regs_reset: assert property ($rose(rst_n) |->
		tapAxisThreshold == REG_RESET && tapDebounceCount == REG_RESET)
		else $error("registers not zero after reset");
endmodule // tcs_chk

bind tcs_tap_config_i2c_slave tcs_chk uChk (.clk, .rst_n, .sclIn, .sdaIn, .sdaOut, .sdaOe,
	.rate120, .autoSleepEn, .tapIntEnable, .tapFlagClear, .tapFlag, .tapEvent, .tapIrq,
	.sleepCountReset, .tapAxisThreshold, .tapDebounceCount);

// >>> testbench/tcs_i2c_master.sv
`timescale 1ns/100ps
module tcs_i2c_master (
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sdaLow
);
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// master alone makes the clock: 5 clk low, 3 clk high
	task automatic bitIo(input logic b, output logic r);
		scl <= 1'b0;
		tick(2);
		sdaLow <= !b;
		tick(3);
		scl <= 1'b1;
		tick(2);
		#1 r = sda;
		tick(1);
	endtask
	// start or stop, data moves while clock high
	task automatic cond(input logic isStart);
		scl <= 1'b0;
		tick(2);
		sdaLow <= !isStart;
		tick(3);
		scl <= 1'b1;
		tick(3);
		sdaLow <= isStart;
		tick(3);
	endtask
	// msb first, ninth clock carries the answer
	task automatic wrByte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitIo(b[i], r);
		bitIo(1'b1, r);
		ack = !r;
	endtask
	// master answers each byte it reads
	task automatic rdByte(input logic nack, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitIo(1'b1, v[i]);
		bitIo(nack, r);
	endtask
endmodule // tcs_i2c_master

// >>> testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top
	import tcs_pkg::*;
;
	logic           clk, rst_n, scl, sdaLow, sdaOut, sdaOe, sda;
	logic           sampleValid, rate120, autoSleepEn, tapIntEnable, tapFlagClear;
	logic           tapFlag, tapEvent, tapIrq, sleepCountReset;
	logic [7:0]     tapAxisThreshold, tapDebounceCount, v;
	logic           a;
	tcs_sample_type sample;
	int             failCount, samplesChecked;
	// pull-up: low when either side pulls
	assign sda = !sdaLow && (sdaOe ? sdaOut : 1'b1);
	tcs_tap_config_i2c_slave #(.SLAVE_ADDR(SLAVE_ADDR_DEFAULT)) DUT (.clk(clk), .rst_n(rst_n),
		.sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .sampleValid(sampleValid),
		.sample(sample), .rate120(rate120), .autoSleepEn(autoSleepEn),
		.tapIntEnable(tapIntEnable), .tapFlagClear(tapFlagClear), .tapFlag(tapFlag),
		.tapEvent(tapEvent), .tapIrq(tapIrq), .sleepCountReset(sleepCountReset),
		.tapAxisThreshold(tapAxisThreshold), .tapDebounceCount(tapDebounceCount));
	tcs_i2c_master uMaster (.clk(clk), .sda(sda), .scl(scl), .sdaLow(sdaLow));
	always #25 clk = ~clk;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			failCount++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic printVerdict();
		$display("mismatches %0d of %0d checks", failCount, samplesChecked);
		if (failCount == 0 && samplesChecked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic addr(input logic rd);
		uMaster.cond(1'b1);
		uMaster.wrByte({SLAVE_ADDR_DEFAULT, rd}, a);
		check({7'h00, a}, 8'h01);
	endtask
	task automatic wrPtr(input logic [7:0] p);
		addr(1'b0);
		uMaster.wrByte(p, a);
		check({7'h00, a}, 8'h01);
	endtask
	task automatic scWrite();
		wrPtr(TAP_AXIS_OFFSET);
		uMaster.wrByte(8'h25, a);
		uMaster.wrByte(8'h01, a);
		uMaster.cond(1'b0);
		check(tapAxisThreshold, 8'h25);
		check(tapDebounceCount, 8'h01);
	endtask
	task automatic scReadBack();
		wrPtr(TAP_AXIS_OFFSET);
		addr(1'b1);
		uMaster.rdByte(1'b0, v);
		check(v, 8'h25);
		uMaster.rdByte(1'b1, v);
		check(v, 8'h01);
		uMaster.rdByte(1'b1, v);
		check(v, 8'hff);
		uMaster.cond(1'b0);
	endtask
	task automatic scStopClear();
		wrPtr(TAP_DEBOUNCE_OFFSET);
		uMaster.cond(1'b0);
		check(tapDebounceCount, 8'h01);
		addr(1'b1);
		uMaster.rdByte(1'b1, v);
		check(v, 8'h00);
		uMaster.cond(1'b0);
	endtask
	task automatic scWrongAddr();
		uMaster.cond(1'b1);
		uMaster.wrByte({SLAVE_ADDR_DEFAULT ^ 7'h01, 1'b0}, a);
		check({7'h00, a}, 8'h00);
		uMaster.wrByte(TAP_DEBOUNCE_OFFSET, a);
		uMaster.wrByte(8'h77, a);
		check({7'h00, a}, 8'h00);
		uMaster.cond(1'b0);
		check(tapDebounceCount, 8'h01);
	endtask
	// magnitude 6 over threshold 5; debounce 1 needs two tests
	task automatic scTap(input logic [7:0] axis, input logic irqEn, input logic r120,
		input logic autoEn, input logic expSleep);
		int   n;
		logic gotIrq, gotSleep;
		wrPtr(TAP_AXIS_OFFSET);
		uMaster.wrByte(axis, a);
		uMaster.cond(1'b0);
		n = 0;
		gotIrq = 1'b0;
		gotSleep = 1'b0;
		tapIntEnable <= irqEn;
		rate120 <= r120;
		autoSleepEn <= autoEn;
		sample <= '{magnitude: 6'd6, axisHit: 3'b111};
		sampleValid <= 1'b1;
		while (tapEvent !== 1'b1 && n < 4 * TEST_CYCLES) begin
			@(posedge clk);
			#1 n++;
		end
		if (n >= 4 * TEST_CYCLES) begin
			failCount++;
			printVerdict();
		end
		check({7'h00, n > TEST_CYCLES && n <= 2 * TEST_CYCLES + 2}, 8'h01);
		repeat (2) begin
			gotIrq |= (tapIrq === 1'b1);
			gotSleep |= (sleepCountReset === 1'b1);
			@(posedge clk);
			#1;
		end
		check({7'h00, gotIrq}, {7'h00, irqEn});
		check({7'h00, gotSleep}, {7'h00, expSleep});
		check({7'h00, tapFlag}, 8'h01);
		@(posedge clk);
		sampleValid <= 1'b0;
		tapFlagClear <= 1'b1;
		@(posedge clk);
		tapFlagClear <= 1'b0;
		@(posedge clk);
		#1 check({7'h00, tapFlag}, 8'h00);
		// let one test see no hit so the next scenario starts from a clean count
		repeat (TEST_CYCLES + 1) @(posedge clk);
	endtask
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		sampleValid = 1'b0;
		sample = '0;
		rate120 = 1'b1;
		autoSleepEn = 1'b1;
		tapIntEnable = 1'b0;
		tapFlagClear = 1'b0;
		failCount = 0;
		samplesChecked = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		check(tapAxisThreshold, REG_RESET);
		check(tapDebounceCount, REG_RESET);
		check({7'h00, sdaOe}, 8'h00);
		scWrite();
		scReadBack();
		scStopClear();
		scWrongAddr();
		scTap(8'h05, 1'b1, 1'b1, 1'b1, 1'b1);
		scTap(8'h85, 1'b0, 1'b1, 1'b1, 1'b0);
		scTap(8'h05, 1'b1, 1'b0, 1'b1, 1'b0);
		scTap(8'h05, 1'b1, 1'b1, 1'b0, 1'b0);
		printVerdict();
	end
endmodule // tb_top
